// file: usm_top.sv
// status interrupt and first mode register control of one serial channel
// Functional notes
// RULE1 - route enables gate summary only, not flags; enable bits 0-3 also gate pin flags 0-3
// RULE2 - pin enable low blocks its flag
// RULE3 - channel zero pins 0-3, one 4-7
// RULE4 - drained flag on empty idle, read clears
// RULE5 - sleep flag: set entry, clear exit/clock off
// RULE6 - clock flag set when settled, crystal only
// RULE7 - clock flag clears only on clock off
// RULE8 - pin flag on level change, read clears
// RULE9 - auto sleep after idle, sets flag
// RULE10 - force sleep; bit reads sleep state
// RULE11 - auto direction: request line follows data
// RULE12 - setup/hold delays; summary bit5 on empty
// RULE13 - tristate bits float request and transmit
// RULE14 - halt finishes character, keeps data, line high
// RULE15 - auto mode: halt reads high when drained (fifo empty and line idle)
// RULE16 - receive halt stops receiver, keeps fifo
// RULE17 - summary is OR of routed flags
`include "usm_cfg.svh"
`default_nettype none
module usm_top #(
    parameter int CHANNEL     = 0,     // channel number, 0 or 1
    parameter int DLY_UNIT    = 16,    // clock cycles per delay step
    parameter int IDLE_CYCLES = 8192   // idle time before auto sleep
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // avalon-mm register slave
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // serial core transmitter side
    input  wire usm_pkg::usm_tx_stat_t tx_stat,
    input  wire logic                 tx_serial_in,
    output logic                      tx_permit,
    output logic                      rx_permit,
    // line pins
    output logic                      tx_o,
    output logic                      tx_oe,
    output logic                      rts_o,
    output logic                      rts_oe,
    input  wire logic                 rts_level_in,
    // general purpose pins, asynchronous
    input  wire logic [7:0]           gpio_in,
    // clock and power status
    input  wire logic                 osc_crystal_sel,
    input  wire logic                 clock_on,
    input  wire logic                 pll_settled,
    input  wire logic                 activity,
    output logic                      sleep_o,
    // summary indications
    output logic                      sts_summary,
    output logic                      txe_summary
);
    import usm_pkg::*;

    localparam int IW = $clog2(IDLE_CYCLES + 1);  // idle counter width

    // register state
    logic [7:0]  enable_r;    // status irq enable
    logic [7:0]  flags_r;     // status irq flags
    logic [7:0]  flags_nxt;   // next flag value
    usm_mode_t   mode_r;      // first mode register
    logic [7:0]  hddelay_r;   // setup [7:4], hold [3:0]
    logic        sum_r;       // registered summary bit
    logic        ack_r;       // bus answer cycle
    logic [31:0] rdata_r;     // read data
    // channel state
    logic        sleep_r;     // channel asleep
    logic        sleep_nxt;   // next sleep state
    usm_dir_t    dir_r;       // direction control state
    usm_dir_t    dir_nxt;     // next direction state
    logic        drained_prev_r; // last drained condition
    logic        settled_prev_r; // last settled condition
    logic [3:0]  pin_prev_r;  // last pin level
    logic        tx_o_r;      // registered transmit pin
    logic        rts_o_r;     // registered request pin
    // derived
    logic [3:0]  pin_s;       // synchronised channel pins
    logic        settled_s;   // synchronised pll settle
    logic        drained;     // fifo empty and line idle
    logic        settled;     // clock settled and valid
    logic        acc;         // bus access completes now
    logic        rd_flags;    // flag register read completes
    logic [5:0]  idx;         // addressed word index
    logic        dly_load;    // load direction delay
    logic [`USM_DLY_W-1:0] dly_val; // direction delay in cycles
    logic        dly_done;    // direction delay elapsed
    logic        idle_load;   // restart idle timer
    logic        idle_done;   // idle time elapsed
    logic        sleep_entry; // sleep starts this cycle

    // word index matches, used by every decode
    function automatic logic reg_hit(input logic [5:0] a,
                                     input logic [5:0] want);
        reg_hit = (a == want);
    endfunction

    // read value of a register word
    function automatic logic [7:0] rd_mux(input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (reg_hit(a, `USM_IDX_ENABLE)) begin
            v = enable_r & `USM_EN_MASK;
        end else if (reg_hit(a, `USM_IDX_FLAGS)) begin
            v = flags_r;
        end else if (reg_hit(a, `USM_IDX_MODE)) begin
            v = mode_r;
            v[5] = sleep_r;                          // RULE10
            if (mode_r.auto_direction_ctrl && drained) begin
                v[1] = 1'b1;                         // RULE15
            end
        end else if (reg_hit(a, `USM_IDX_SUMMARY)) begin
            v[`USM_SUM_STS] = sum_r;
            v[`USM_SUM_TXE] = txe_summary;
        end else if (reg_hit(a, `USM_IDX_HDDELAY)) begin
            v = hddelay_r;
        end
        rd_mux = v;
    endfunction

    // pin and pll synchronisers
    usm_sync #(.W(4)) u_pin_sync (
        .clk (clk),
        .rst (rst),
        .d   (gpio_in[CHANNEL*4 +: 4]),  // RULE3
        .q   (pin_s)
    );

    usm_sync #(.W(1)) u_pll_sync (
        .clk (clk),
        .rst (rst),
        .d   (pll_settled),
        .q   (settled_s)
    );

    // bus decode: one wait state, answer on the second cycle
    assign idx             = avs_address[7:2];
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign acc             = (avs_read || avs_write) && ack_r;
    assign rd_flags        = acc && avs_read &&
                             reg_hit(idx, `USM_IDX_FLAGS);
    assign avs_readdata    = rdata_r;

    // answer timing and read data capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r   <= (avs_read || avs_write) && !ack_r;
            rdata_r <= {24'h00_0000, rd_mux(idx)};
        end
    end

    // software writable registers, low byte lane only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_r  <= `USM_RST_ENABLE;
            mode_r    <= `USM_RST_MODE;
            hddelay_r <= `USM_RST_HDDELAY;
        end else if (acc && avs_write && avs_byteenable[0]) begin
            if (reg_hit(idx, `USM_IDX_ENABLE)) begin
                enable_r <= avs_writedata[7:0] & `USM_EN_MASK;
            end
            if (reg_hit(idx, `USM_IDX_MODE)) begin
                mode_r <= usm_mode_t'(avs_writedata[7:0] & 8'h7f);
            end
            if (reg_hit(idx, `USM_IDX_HDDELAY)) begin
                hddelay_r <= avs_writedata[7:0];
            end
        end
    end

    // status conditions
    assign drained = tx_stat.fifo_empty && tx_stat.shift_idle;
    assign settled = settled_s && osc_crystal_sel && clock_on; // RULE6

    // next flag value, set always wins over clear
    always_comb begin
        flags_nxt = flags_r;
        if (rd_flags) begin
            flags_nxt = flags_r & ~(rdata_r[7:0] & `USM_RD_CLR_MASK); // RULE4
        end
        if (drained && !drained_prev_r) begin
            flags_nxt[`USM_BIT_TXD] = 1'b1;           // RULE4
        end
        if (!sleep_r || !clock_on) begin
            flags_nxt[`USM_BIT_SLP] = 1'b0;           // RULE5
        end
        if (sleep_entry) begin
            flags_nxt[`USM_BIT_SLP] = 1'b1;           // RULE5 RULE9
        end
        if (!clock_on) begin
            flags_nxt[`USM_BIT_CLK] = 1'b0;           // RULE7
        end else if (settled && !settled_prev_r) begin
            flags_nxt[`USM_BIT_CLK] = 1'b1;           // RULE6
        end
        for (int i = 0; i < 4; i++) begin
            if (enable_r[i] && (pin_s[i] != pin_prev_r[i])) begin
                flags_nxt[i] = 1'b1;                  // RULE2 RULE8
            end
        end
        flags_nxt[4] = 1'b0;
    end

    // flag register and edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_r        <= `USM_RST_FLAGS;
            drained_prev_r <= 1'b0;
            settled_prev_r <= 1'b0;
            pin_prev_r     <= 4'h0;
        end else begin
            flags_r        <= flags_nxt;
            drained_prev_r <= drained;
            settled_prev_r <= settled;
            pin_prev_r     <= pin_s;
        end
    end

    // summary is the or of flags whose route is enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sum_r <= 1'b0;
        end else begin
            sum_r <= |(flags_r & enable_r & `USM_EN_MASK); // RULE1 RULE17
        end
    end
    assign sts_summary = sum_r;
    assign txe_summary = mode_r.auto_direction_ctrl &&
                         tx_stat.fifo_empty;          // RULE12

    // idle timer restarts on any activity or while it is not armed
    assign idle_load = activity || !mode_r.auto_sleep || sleep_r;
    usm_count #(.W(IW)) u_idle (
        .clk   (clk),
        .rst   (rst),
        .load  (idle_load),
        .value (IW'(IDLE_CYCLES)),
        .done  (idle_done)
    );

    // sleep decision
    always_comb begin
        sleep_nxt = sleep_r;
        if (mode_r.sleep_force) begin
            sleep_nxt = 1'b1;                         // RULE10
        end else if (!mode_r.auto_sleep) begin
            sleep_nxt = 1'b0;
        end else if (sleep_r && activity) begin
            sleep_nxt = 1'b0;
        end else if (idle_done) begin
            sleep_nxt = 1'b1;                         // RULE9
        end
    end
    assign sleep_entry = sleep_nxt && !sleep_r;

    // sleep state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_r <= 1'b0;
        end else begin
            sleep_r <= sleep_nxt;
        end
    end
    assign sleep_o = sleep_r;

    // direction delay timer, setup on entry to send, hold after it
    assign dly_val = (dir_r == USM_DIR_RX) ?
        `USM_DLY_W'(hddelay_r[7:4] * DLY_UNIT) :
        `USM_DLY_W'(hddelay_r[3:0] * DLY_UNIT);      // RULE12
    assign dly_load = (dir_nxt != dir_r) &&
        ((dir_nxt == USM_DIR_SETUP) || (dir_nxt == USM_DIR_HOLD));
    usm_count #(.W(`USM_DLY_W)) u_dly (
        .clk   (clk),
        .rst   (rst),
        .load  (dly_load),
        .value (dly_val),
        .done  (dly_done)
    );

    // direction control sequence
    always_comb begin
        dir_nxt = dir_r;
        unique case (dir_r)
            USM_DIR_RX: begin
                if (!tx_stat.fifo_empty && !mode_r.tx_halt) begin
                    dir_nxt = USM_DIR_SETUP;          // RULE11
                end
            end
            USM_DIR_SETUP: begin
                if (dly_done) begin
                    dir_nxt = USM_DIR_SEND;
                end
            end
            USM_DIR_SEND: begin
                if (drained || (mode_r.tx_halt && tx_stat.shift_idle)) begin
                    dir_nxt = USM_DIR_HOLD;           // RULE11
                end
            end
            USM_DIR_HOLD: begin
                if (dly_done) begin
                    dir_nxt = USM_DIR_RX;
                end
            end
        endcase
        if (!mode_r.auto_direction_ctrl) begin
            dir_nxt = USM_DIR_RX;
        end
    end

    // direction state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dir_r <= USM_DIR_RX;
        end else begin
            dir_r <= dir_nxt;
        end
    end

    // serial core permits; the core checks tx_permit between characters
    assign tx_permit = !mode_r.tx_halt && !sleep_r &&
        (!mode_r.auto_direction_ctrl || dir_r == USM_DIR_SEND); // RULE14
    assign rx_permit = !mode_r.rx_halt && !sleep_r;  // RULE16

    // line pins: transmit forced high once halted and idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_o_r  <= 1'b1;
            rts_o_r <= 1'b0;
        end else begin
            tx_o_r  <= tx_serial_in ||
                       (mode_r.tx_halt && tx_stat.shift_idle); // RULE14
            rts_o_r <= mode_r.auto_direction_ctrl ?
                       (dir_r != USM_DIR_RX) : rts_level_in;   // RULE11
        end
    end
    assign tx_o   = tx_o_r;
    assign rts_o  = rts_o_r;
    assign tx_oe  = !mode_r.tx_out_tristate;         // RULE13
    assign rts_oe = !mode_r.rts_out_tristate;        // RULE13

    // checks on the block's own outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SUM_ROUTE: assert property ( // RULE17
        ##1 sum_r == $past(|(flags_r & enable_r & `USM_EN_MASK)))
        else $error("summary does not match routed flags");
    AST_ROUTE_NO_FLAG: assert property ( // RULE1
        !enable_r[`USM_BIT_TXD] && !rd_flags && flags_r[`USM_BIT_TXD]
        |=> flags_r[`USM_BIT_TXD])
        else $error("route enable changed drained flag");
    AST_PIN_GATE: assert property ( // RULE2
        !enable_r[0] && !flags_r[0] |=> !flags_r[0])
        else $error("pin flag set while disabled");
    AST_DRAIN_SET: assert property ( // RULE4
        drained && !drained_prev_r |=> flags_r[`USM_BIT_TXD])
        else $error("drained flag not set");
    AST_SLEEP_KEEP: assert property ( // RULE5
        flags_r[`USM_BIT_SLP] && sleep_nxt && clock_on
        |=> flags_r[`USM_BIT_SLP])
        else $error("sleep flag lost while asleep");
    AST_CLK_XTAL: assert property ( // RULE6
        !osc_crystal_sel && !flags_r[`USM_BIT_CLK]
        |=> !flags_r[`USM_BIT_CLK])
        else $error("clock flag set without crystal");
    AST_CLK_KEEP: assert property ( // RULE7
        flags_r[`USM_BIT_CLK] && clock_on |=> flags_r[`USM_BIT_CLK])
        else $error("clock flag cleared while clock on");
    AST_FORCE_SLEEP: assert property ( // RULE10
        mode_r.sleep_force |=> sleep_r)
        else $error("forced sleep not entered");
    AST_RTS_BEFORE_TX: assert property ( // RULE11
        mode_r.auto_direction_ctrl && tx_permit |-> rts_o_r)
        else $error("send permitted with request line low");
    AST_HALT_READS: assert property ( // RULE15
        avs_read && !ack_r && reg_hit(idx, `USM_IDX_MODE) &&
        mode_r.auto_direction_ctrl && drained |=> avs_readdata[1])
        else $error("halt bit not high when drained");
    AST_RX_HALT: assert property ( // RULE16
        mode_r.rx_halt |-> !rx_permit)
        else $error("receiver permitted while halted");
    AST_BUS_ANSWER: assert property (
        avs_read || avs_write |-> ##[0:1] !avs_waitrequest)
        else $error("bus answer late");

    COV_PIN_FLAG: cover property (enable_r[0] ##1 flags_r[0]);
    COV_AUTO_SEND: cover property (
        dir_r == USM_DIR_SETUP ##[1:20] dir_r == USM_DIR_SEND);
    COV_AUTO_SLEEP: cover property (mode_r.auto_sleep && sleep_entry);
    COV_FLAG_READ: cover property (rd_flags && flags_r[`USM_BIT_TXD]);

endmodule
`default_nettype wire

// file: usm_cfg.svh
// offsets, field positions, reset values and delay counter width of the channel
`ifndef USM_CFG_SVH
`define USM_CFG_SVH

// register word indices (byte address is four times the index)
`define USM_IDX_ENABLE   6'h07
`define USM_IDX_FLAGS    6'h08
`define USM_IDX_MODE     6'h09
`define USM_IDX_SUMMARY  6'h10
`define USM_IDX_HDDELAY  6'h11

// status flag and route enable bit positions
`define USM_BIT_TXD      7
`define USM_BIT_SLP      6
`define USM_BIT_CLK      5
`define USM_PIN_MASK     8'h0f
`define USM_RD_CLR_MASK  8'h8f
`define USM_EN_MASK      8'hef

// summary register bit positions
`define USM_SUM_STS      2
`define USM_SUM_TXE      5

// reset values
`define USM_RST_ENABLE   8'h00
`define USM_RST_FLAGS    8'h00
`define USM_RST_MODE     8'h00
`define USM_RST_HDDELAY  8'h00

// direction delay counter width
`define USM_DLY_W        12

`endif

// file: usm_pkg.sv
// types shared by the channel status and mode control block
`default_nettype none
package usm_pkg;

    // direction control states
    typedef enum logic [1:0] {
        USM_DIR_RX    = 2'b00,
        USM_DIR_SETUP = 2'b01,
        USM_DIR_SEND  = 2'b10,
        USM_DIR_HOLD  = 2'b11
    } usm_dir_t;

    // transmitter state reported by the serial core
    typedef struct packed {
        logic fifo_empty;   // transmit fifo holds no data
        logic shift_idle;   // last character has left the line
    } usm_tx_stat_t;

    // layout of the first mode register
    typedef struct packed {
        logic rsv;                  // bit 7, no function
        logic auto_sleep;           // bit 6
        logic sleep_force;          // bit 5
        logic auto_direction_ctrl;  // bit 4
        logic rts_out_tristate;     // bit 3
        logic tx_out_tristate;      // bit 2
        logic tx_halt;              // bit 1
        logic rx_halt;              // bit 0
    } usm_mode_t;

endpackage
`default_nettype wire

// file: usm_sync.sv
// two flip-flop level synchroniser for asynchronous inputs
`default_nettype none
module usm_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // async in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;  // first stage, read only by the second

    // two stage capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule
`default_nettype wire

// file: usm_count.sv
// loadable down counter that reports when it has run out
`default_nettype none
module usm_count #(
    parameter int W = 12
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // load strobe and value
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    // count reached zero
    output logic              done
);

    logic [W-1:0] count_r;  // remaining cycles

    // load wins, otherwise count down to zero and stay
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= value;
        end else if (count_r != '0) begin
            count_r <= count_r - W'(1);
        end
    end

    // done is held off while a new count is loaded
    assign done = (count_r == '0) && !load;

endmodule
`default_nettype wire

// file: usm_xcvr_model.sv
// serial core and line transceiver model at the far side of the channel
`default_nettype none
module usm_xcvr_model (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // bench loads one character per cycle of push
    input  wire logic           push,
    // start permission from the channel
    input  wire logic           tx_permit,
    // transmitter state and serial bit towards the channel
    output usm_pkg::usm_tx_stat_t tx_stat,
    output logic                tx_serial_in,
    // characters still waiting in the transmit fifo
    output int                  level
);
    timeunit 1ns;
    timeprecision 1ps;
    import usm_pkg::*;

    logic [4:0] cnt_r;  // cycles left in the current frame
    logic [9:0] sh_r;   // frame shifter, lsb on the line
    logic       start;  // a new character leaves the fifo

    // a character starts only while the channel permits it
    assign start = tx_permit && cnt_r == 5'h00 && level > 0;
    assign tx_serial_in = sh_r[0];
    assign tx_stat = {level == 0, cnt_r == 5'h00};

    // fifo level and frame shifter, two cycles per bit, idle high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 0;
            cnt_r <= 5'h00;
            sh_r  <= 10'h3ff;
        end else begin
            level <= level + int'(push) - int'(start);
            if (start) begin
                cnt_r <= 5'h14;
                sh_r  <= {1'b1, 8'h5a, 1'b0};
            end else if (cnt_r != 5'h00) begin
                cnt_r <= cnt_r - 5'h01;
                if (cnt_r[0]) begin
                    sh_r <= {1'b1, sh_r[9:1]};
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb_uart_status_irq_mode_ctrl.sv
// self-checking bench of the status and mode block
`default_nettype none
module tb_uart_status_irq_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import usm_pkg::*;

    logic        clk, rst, avs_read, avs_write, activity, push;
    logic        avs_waitrequest, tx_serial_in, tx_permit, rx_permit;
    logic        tx_o, tx_oe, rts_o, rts_oe, sleep_o;
    logic        osc_crystal_sel, clock_on, pll_settled;
    logic        sts_summary, txe_summary;
    logic [7:0]  avs_address, gpio_in, r, old, e;
    logic [31:0] avs_writedata, avs_readdata;
    usm_tx_stat_t tx_stat;
    int          level, n_mismatch, samples_checked, i;
    logic [15:0] expq[$], nt;  // pending reads: mask, expected

    usm_top #(.CHANNEL(1), .DLY_UNIT(1), .IDLE_CYCLES(16)) dut_u (
        .clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_stat(tx_stat), .tx_serial_in(tx_serial_in),
        .tx_permit(tx_permit), .rx_permit(rx_permit), .tx_o(tx_o),
        .tx_oe(tx_oe), .rts_o(rts_o), .rts_oe(rts_oe),
        .rts_level_in(1'b0), .gpio_in(gpio_in),
        .osc_crystal_sel(osc_crystal_sel), .clock_on(clock_on),
        .pll_settled(pll_settled), .activity(activity),
        .sleep_o(sleep_o), .sts_summary(sts_summary),
        .txe_summary(txe_summary));

    usm_xcvr_model xcvr_u (
        .clk(clk), .rst(rst), .push(push), .tx_permit(tx_permit),
        .tx_stat(tx_stat), .tx_serial_in(tx_serial_in), .level(level));

    // free running clock, 8 ns period
    always #4 clk = ~clk;

    // printed verdict, the only end of the run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // one comparison, counted
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    // lfsr step for random pin values
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // watched signal by selector
    function automatic logic sig(input int k);
        case (k)
            0: return rts_o;
            1: return tx_stat.fifo_empty & tx_stat.shift_idle;
            2: return sleep_o;
            3: return tx_o;
            default: return tx_stat.shift_idle;
        endcase
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bounded wait for a signal level
    task automatic await(input int k, input logic v);
        for (int j = 0; j < 2000; j++) begin
            @(posedge clk);
            if (sig(k) === v) return;
        end
        n_mismatch++;
        wrap_up();
    endtask

    // one avalon transfer, held until waitrequest low
    task automatic bus(input logic [7:0] a, input logic is_rd,
                       input logic [7:0] d);
        int j;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_read      <= is_rd;
        avs_write     <= !is_rd;
        for (j = 0; j < 50; j++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (j == 50) begin
            n_mismatch++;
            wrap_up();
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // read with expected value under a mask
    task automatic rd(input logic [7:0] a, m, x);
        expq.push_back({m, x});
        bus(a, 1'b1, 8'h00);
    endtask

    // load characters into the far side fifo
    task automatic load(input int n);
        repeat (n) @(posedge clk) push <= 1'b1;
        @(posedge clk) push <= 1'b0;
    endtask

    // read monitor: oldest note vs answer
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            nt = expq.pop_front();
            chk(avs_readdata[7:0] & nt[15:8], nt[7:0]);
        end
    end

    // main sequence
    initial begin
        {clk, avs_read, avs_write, activity, push, pll_settled} = '0;
        {osc_crystal_sel, avs_address, avs_writedata, gpio_in} = '0;
        {n_mismatch, samples_checked} = '0;
        rst = 1'b1;
        clock_on = 1'b1;
        r = 8'h46;
        old = 8'h00;
        wt(3);
        rst <= 1'b0;
        // reset values and an unmapped place
        rd(8'h1c, 8'hff, 8'h00);
        rd(8'h24, 8'hff, 8'h00);
        rd(8'h3c, 8'hff, 8'h00);
        // drained flag routed, then unrouted
        bus(8'h1c, 1'b0, 8'h80);
        wt(3);
        rd(8'h40, 8'h04, 8'h04);
        chk({7'h0, sts_summary}, 8'h01);
        bus(8'h1c, 1'b0, 8'h00);
        wt(3);
        rd(8'h40, 8'h04, 8'h00);
        rd(8'h20, 8'hff, 8'h80);
        rd(8'h20, 8'hff, 8'h00);
        bus(8'h1c, 1'b0, 8'hff);
        rd(8'h1c, 8'hff, 8'hef);
        // pin change flags of pins 4 to 7, three of four enabled
        bus(8'h1c, 1'b0, 8'h07);
        for (i = 0; i < 3; i++) begin
            r = lfsr(r);
            gpio_in <= r;
            wt(6);
            e = ((old ^ r) >> 4) & 8'h07;
            old = r;
            rd(8'h40, 8'h04, (e != 0) ? 8'h04 : 8'h00);
            rd(8'h20, 8'h0f, e);
            rd(8'h20, 8'h0f, 8'h00);
        end
        // clock settled flag: external clock, then crystal
        pll_settled <= 1'b1;
        wt(6);
        rd(8'h20, 8'h20, 8'h00);
        osc_crystal_sel <= 1'b1;
        wt(6);
        rd(8'h20, 8'h20, 8'h20);
        rd(8'h20, 8'h20, 8'h20);
        // forced sleep, then clock off
        bus(8'h24, 1'b0, 8'h20);
        wt(3);
        chk({7'h0, sleep_o}, 8'h01);
        rd(8'h24, 8'hff, 8'h20);
        rd(8'h20, 8'h40, 8'h40);
        rd(8'h20, 8'h40, 8'h40);
        clock_on <= 1'b0;
        wt(3);
        rd(8'h20, 8'h60, 8'h00);
        clock_on <= 1'b1;
        bus(8'h24, 1'b0, 8'h00);
        // automatic sleep after idle time, woken by activity
        bus(8'h24, 1'b0, 8'h40);
        activity <= 1'b1;
        wt(1);
        activity <= 1'b0;
        wt(8);
        chk({7'h0, sleep_o}, 8'h00);
        await(2, 1'b1);
        rd(8'h24, 8'hff, 8'h60);
        rd(8'h20, 8'h40, 8'h40);
        activity <= 1'b1;
        wt(1);
        activity <= 1'b0;
        await(2, 1'b0);
        bus(8'h24, 1'b0, 8'h00);
        rd(8'h20, 8'h40, 8'h00);
        // three-state of request and transmit pins
        bus(8'h24, 1'b0, 8'h08);
        wt(2);
        chk({6'h0, rts_oe, tx_oe}, 8'h01);
        bus(8'h24, 1'b0, 8'h04);
        wt(2);
        chk({6'h0, rts_oe, tx_oe}, 8'h02);
        // receive halt
        bus(8'h24, 1'b0, 8'h01);
        wt(2);
        chk({7'h0, rx_permit}, 8'h00);
        // transmit halt in mid character keeps the rest queued
        bus(8'h24, 1'b0, 8'h00);
        load(3);
        await(3, 1'b0);
        bus(8'h24, 1'b0, 8'h02);
        await(4, 1'b1);
        wt(30);
        chk(8'(level), 8'h02);
        chk({7'h0, tx_o}, 8'h01);
        bus(8'h24, 1'b0, 8'h00);
        await(1, 1'b1);
        // automatic direction with one step of setup and hold
        bus(8'h44, 1'b0, 8'h11);
        bus(8'h24, 1'b0, 8'h10);
        wt(3);
        chk({7'h0, rts_o}, 8'h00);
        load(2);
        await(0, 1'b1);
        chk({7'h0, tx_o}, 8'h01);
        await(1, 1'b1);
        chk({7'h0, rts_o}, 8'h01);
        chk({7'h0, txe_summary}, 8'h01);
        rd(8'h40, 8'h20, 8'h20);
        rd(8'h24, 8'hff, 8'h12);
        await(0, 1'b0);
        wt(2);
        wrap_up();
    end
endmodule
`default_nettype wire
